// file: design/cpurf_pkg.sv
// Package for the CPU register set: register indices, field positions,
// reset values and the carrier structs shared by the core and its users.
// Assumes a word-addressed Wishbone map where byte address = index * 4.
package cpurf_pkg;

  // Widths of the architectural registers
  localparam int DATA_W = 16;
  localparam int ADDR_W = 20;
  localparam int FLAG_W = 11;
  localparam int IPL_W = 3;
  localparam int IDX_W = 5;
  localparam int BANKS = 2;
  localparam int BANK_REGS = 7;

  // Register indices; byte address on the bus is index * 4
  localparam logic [4:0] IDX_DATA0 = 5'h00;
  localparam logic [4:0] IDX_DATA1 = 5'h01;
  localparam logic [4:0] IDX_DATA2 = 5'h02;
  localparam logic [4:0] IDX_DATA3 = 5'h03;
  localparam logic [4:0] IDX_ADDR0 = 5'h04;
  localparam logic [4:0] IDX_ADDR1 = 5'h05;
  localparam logic [4:0] IDX_FRAME = 5'h06;
  localparam logic [4:0] IDX_VTAB = 5'h07;
  localparam logic [4:0] IDX_PC = 5'h08;
  localparam logic [4:0] IDX_USP = 5'h09;
  localparam logic [4:0] IDX_ISP = 5'h0a;
  localparam logic [4:0] IDX_SBASE = 5'h0b;
  localparam logic [4:0] IDX_FLAGS = 5'h0c;
  localparam logic [4:0] IDX_ACT_SP = 5'h0d;
  localparam logic [4:0] IDX_WIDE_LO = 5'h0e;
  localparam logic [4:0] IDX_WIDE_HI = 5'h0f;
  localparam logic [4:0] IDX_WIDE_ADDR = 5'h10;
  localparam logic [4:0] IDX_IRQ_STAT = 5'h11;

  // Flag field positions in the status word
  localparam int FLG_CARRY = 0;
  localparam int FLG_DEBUG = 1;
  localparam int FLG_ZERO = 2;
  localparam int FLG_SIGN = 3;
  localparam int FLG_BANK = 4;
  localparam int FLG_OVF = 5;
  localparam int FLG_IEN = 6;
  localparam int FLG_STACK = 7;
  localparam int FLG_IPL_LSB = 8;
  localparam int FLG_RSVD = 11;

  // Reset values
  localparam logic [15:0] DATA_RST = 16'h0000;
  localparam logic [19:0] ADDR_RST = 20'h00000;
  localparam logic [10:0] FLAG_RST = 11'h000;

  // Software interrupt numbers up to this one switch to the interrupt stack
  localparam logic [5:0] SWI_STACK_MAX = 6'h1f;

  // Status word as stored
  typedef struct packed {
    logic [2:0] processor_priority_level;
    logic stack_sel;
    logic irq_en;
    logic ovf;
    logic bank_sel;
    logic sign;
    logic zero;
    logic debug;
    logic carry;
  } cpurf_flags_type;

  // One write request into the register set
  typedef struct packed {
    logic we;
    logic [4:0] idx;
    logic [3:0] be;
    logic [31:0] data;
  } cpurf_wr_type;

  // Result handed over by the arithmetic unit
  typedef struct packed {
    logic upd;
    logic byte_op;
    logic [15:0] result;
    logic carry;
    logic ovf;
  } cpurf_alu_type;

endpackage

// file: design/cpurf_core.sv
// CPU register set with status flags, interrupt acceptance and a
// Wishbone classic slave for register access.
// Assumes the execution datapath and interrupt logic share clk_i and
// drive their inputs synchronously; reset is synchronous, active high.
// Contract
// - Four 16-bit general data registers for transfer and arithmetic.
// - First two data registers split into independent upper and lower bytes.
// - Third joins first, fourth joins second, forming two 32-bit registers.
// - Two 16-bit address registers, combinable into one 32-bit register.
// - 16-bit frame base register for frame-relative addressing.
// - 20-bit register holding interrupt vector table start address.
// - 20-bit program counter holds the next instruction address.
// - Separate 16-bit user and interrupt stack pointers, chosen by stack flag.
// - 16-bit static base register for static-base-relative addressing.
// - 11-bit status register holds condition, bank, stack, enable, level fields.
// - Carry flag captures carry, borrow or shifted-out bit from the ALU.
// - Zero flag is one when an arithmetic result is zero.
// - Sign flag is one when an arithmetic result is negative.
// - Bank flag zero selects bank 0, one selects bank 1.
// - Overflow flag is one when an operation overflows.
// - Maskable interrupts blocked while enable flag is zero.
// - Acknowledging an interrupt clears the interrupt enable flag.
// - Stack flag zero selects interrupt pointer, one selects user pointer.
// - Hardware acknowledge or software interrupt 0 to 31 clears stack flag.
// - Three-bit level; a request is taken only above the current level.
// - Reserved status bit: write zero; its read value is undefined.
`timescale 1ns/10ps
module cpurf_core #(
  parameter int PC_W = cpurf_pkg::ADDR_W,
  parameter int VTAB_W = cpurf_pkg::ADDR_W
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Execution datapath
  input wire cpurf_pkg::cpurf_wr_type ex_wr_i,
  input wire logic [4:0] ex_ridx_i,
  output logic [31:0] ex_rdata_o,
  input wire cpurf_pkg::cpurf_alu_type alu_i,
  // Interrupt acceptance
  input wire logic irq_req_i,
  input wire logic irq_maskable_i,
  input wire logic [2:0] irq_level_i,
  input wire logic irq_ack_i,
  input wire logic swi_exec_i,
  input wire logic [5:0] swi_num_i,
  output logic irq_accept_o,
  // Register views for the rest of the core
  output logic [PC_W-1:0] pc_o,
  output logic [VTAB_W-1:0] vtab_o,
  output logic [15:0] active_sp_o,
  output logic [15:0] frame_base_o,
  output logic [15:0] static_base_o,
  output cpurf_pkg::cpurf_flags_type flags_o
);

  // Widths that the 32-bit word views cannot carry are refused
  initial begin
    if (PC_W < 16 || PC_W > 32 || VTAB_W < 16 || VTAB_W > 32) begin
      $error("cpurf_core: address widths must lie in 16..32");
    end
  end

  // Storage: banked general registers, then the unbanked ones
  logic [15:0] bank_regs [0:cpurf_pkg::BANKS-1][0:cpurf_pkg::BANK_REGS-1];
  logic [15:0] user_sp;
  logic [15:0] irq_sp;
  logic [15:0] static_base;
  logic [VTAB_W-1:0] vtab;
  logic [PC_W-1:0] pc;
  cpurf_pkg::cpurf_flags_type flags;

  // Bus request decode
  logic bus_req;
  logic [4:0] bus_idx;
  cpurf_pkg::cpurf_wr_type bus_wr;
  cpurf_pkg::cpurf_wr_type wr_port [0:1];
  logic bank;

  assign bus_req = wb_cyc_i & wb_stb_i;
  assign bus_idx = wb_adr_i[6:2];
  assign bank = flags.bank_sel;

  // Write takes effect on the edge where the master sees ack
  always_comb begin
    bus_wr.we = bus_req & wb_we_i & wb_ack_o & ~wb_adr_i[7];
    bus_wr.idx = bus_idx;
    bus_wr.be = wb_sel_i;
    bus_wr.data = wb_dat_i;
  end

  // Port 1 is applied last, so the datapath wins a same-cycle clash
  assign wr_port[0] = bus_wr;
  assign wr_port[1] = ex_wr_i;

  // Word view of any index, in the current bank
  function automatic logic [31:0] read_word(input logic [4:0] idx);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (idx)
      cpurf_pkg::IDX_DATA0, cpurf_pkg::IDX_DATA1, cpurf_pkg::IDX_DATA2,
      cpurf_pkg::IDX_DATA3, cpurf_pkg::IDX_ADDR0, cpurf_pkg::IDX_ADDR1,
      cpurf_pkg::IDX_FRAME: begin
        w[15:0] = bank_regs[bank][idx[2:0]];
      end
      cpurf_pkg::IDX_VTAB: w[VTAB_W-1:0] = vtab;
      cpurf_pkg::IDX_PC: w[PC_W-1:0] = pc;
      cpurf_pkg::IDX_USP: w[15:0] = user_sp;
      cpurf_pkg::IDX_ISP: w[15:0] = irq_sp;
      cpurf_pkg::IDX_SBASE: w[15:0] = static_base;
      // Reserved bit reads as zero, one legal undefined value
      cpurf_pkg::IDX_FLAGS: w[cpurf_pkg::FLAG_W-1:0] = flags;
      cpurf_pkg::IDX_ACT_SP: begin
        w[15:0] = flags.stack_sel ? user_sp : irq_sp;
      end
      cpurf_pkg::IDX_WIDE_LO: begin
        w = {bank_regs[bank][2], bank_regs[bank][0]};
      end
      cpurf_pkg::IDX_WIDE_HI: begin
        w = {bank_regs[bank][3], bank_regs[bank][1]};
      end
      cpurf_pkg::IDX_WIDE_ADDR: begin
        w = {bank_regs[bank][5], bank_regs[bank][4]};
      end
      cpurf_pkg::IDX_IRQ_STAT: begin
        w[0] = irq_accept_o;
        w[3:1] = flags.processor_priority_level;
      end
      default: w = 32'h0000_0000;
    endcase
    return w;
  endfunction

  // Byte-lane merge; each byte lane stands alone
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [15:0] nw,
                                          input logic [1:0] be);
    logic [15:0] m;
    m = old;
    if (be[0]) begin
      m[7:0] = nw[7:0];
    end
    if (be[1]) begin
      m[15:8] = nw[15:8];
    end
    return m;
  endfunction

  // Banked general registers, single and paired access
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int b = 0; b < cpurf_pkg::BANKS; b++) begin
        for (int r = 0; r < cpurf_pkg::BANK_REGS; r++) begin
          bank_regs[b][r] <= cpurf_pkg::DATA_RST;
        end
      end
    end else begin
      for (int p = 0; p < 2; p++) begin
        if (wr_port[p].we) begin
          case (wr_port[p].idx)
            cpurf_pkg::IDX_DATA0, cpurf_pkg::IDX_DATA1, cpurf_pkg::IDX_DATA2,
            cpurf_pkg::IDX_DATA3, cpurf_pkg::IDX_ADDR0, cpurf_pkg::IDX_ADDR1,
            cpurf_pkg::IDX_FRAME: begin
              // Byte lanes give the independent upper and lower halves
              bank_regs[bank][wr_port[p].idx[2:0]] <= merge16(
                bank_regs[bank][wr_port[p].idx[2:0]],
                wr_port[p].data[15:0], wr_port[p].be[1:0]);
            end
            cpurf_pkg::IDX_WIDE_LO: begin
              bank_regs[bank][0] <= merge16(bank_regs[bank][0],
                wr_port[p].data[15:0], wr_port[p].be[1:0]);
              bank_regs[bank][2] <= merge16(bank_regs[bank][2],
                wr_port[p].data[31:16], wr_port[p].be[3:2]);
            end
            cpurf_pkg::IDX_WIDE_HI: begin
              bank_regs[bank][1] <= merge16(bank_regs[bank][1],
                wr_port[p].data[15:0], wr_port[p].be[1:0]);
              bank_regs[bank][3] <= merge16(bank_regs[bank][3],
                wr_port[p].data[31:16], wr_port[p].be[3:2]);
            end
            cpurf_pkg::IDX_WIDE_ADDR: begin
              bank_regs[bank][4] <= merge16(bank_regs[bank][4],
                wr_port[p].data[15:0], wr_port[p].be[1:0]);
              bank_regs[bank][5] <= merge16(bank_regs[bank][5],
                wr_port[p].data[31:16], wr_port[p].be[3:2]);
            end
            default: begin
            end
          endcase
        end
      end
    end
  end

  // Stack pointers; the active-pointer alias follows the stack flag
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      user_sp <= cpurf_pkg::DATA_RST;
      irq_sp <= cpurf_pkg::DATA_RST;
    end else begin
      for (int p = 0; p < 2; p++) begin
        if (wr_port[p].we) begin
          if (wr_port[p].idx == cpurf_pkg::IDX_USP ||
              (wr_port[p].idx == cpurf_pkg::IDX_ACT_SP && flags.stack_sel)) begin
            user_sp <= merge16(user_sp, wr_port[p].data[15:0],
                               wr_port[p].be[1:0]);
          end
          if (wr_port[p].idx == cpurf_pkg::IDX_ISP ||
              (wr_port[p].idx == cpurf_pkg::IDX_ACT_SP && !flags.stack_sel)) begin
            irq_sp <= merge16(irq_sp, wr_port[p].data[15:0],
                              wr_port[p].be[1:0]);
          end
        end
      end
    end
  end

  // Static base, vector table base and program counter
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      static_base <= cpurf_pkg::DATA_RST;
      vtab <= VTAB_W'(cpurf_pkg::ADDR_RST);
      pc <= PC_W'(cpurf_pkg::ADDR_RST);
    end else begin
      for (int p = 0; p < 2; p++) begin
        if (wr_port[p].we) begin
          case (wr_port[p].idx)
            cpurf_pkg::IDX_SBASE: begin
              static_base <= merge16(static_base, wr_port[p].data[15:0],
                                     wr_port[p].be[1:0]);
            end
            // Wide registers take whole words only; partial lanes ignored
            cpurf_pkg::IDX_VTAB: begin
              if (&wr_port[p].be) begin
                vtab <= wr_port[p].data[VTAB_W-1:0];
              end
            end
            cpurf_pkg::IDX_PC: begin
              if (&wr_port[p].be) begin
                pc <= wr_port[p].data[PC_W-1:0];
              end
            end
            default: begin
            end
          endcase
        end
      end
    end
  end

  // Condition flags from the arithmetic unit
  logic next_zero;
  logic next_sign;
  always_comb begin
    if (alu_i.byte_op) begin
      next_zero = (alu_i.result[7:0] == 8'h00);
      next_sign = alu_i.result[7];
    end else begin
      next_zero = (alu_i.result == 16'h0000);
      next_sign = alu_i.result[15];
    end
  end

  // Status register; hardware events override a same-cycle write
  logic flags_wr;
  logic [10:0] flags_wdata;
  always_comb begin
    flags_wr = 1'b0;
    flags_wdata = flags;
    for (int p = 0; p < 2; p++) begin
      if (wr_port[p].we && wr_port[p].idx == cpurf_pkg::IDX_FLAGS) begin
        flags_wr = 1'b1;
        if (wr_port[p].be[0]) begin
          flags_wdata[7:0] = wr_port[p].data[7:0];
        end
        if (wr_port[p].be[1]) begin
          flags_wdata[10:8] = wr_port[p].data[10:8];
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags <= cpurf_pkg::FLAG_RST;
    end else begin
      if (flags_wr) begin
        // Debug flag stored as written; software keeps it at zero
        flags <= flags_wdata;
      end
      if (alu_i.upd) begin
        flags.carry <= alu_i.carry;
        flags.zero <= next_zero;
        flags.sign <= next_sign;
        flags.ovf <= alu_i.ovf;
      end
      if (irq_ack_i) begin
        flags.irq_en <= 1'b0;
        flags.stack_sel <= 1'b0;
      end
      if (swi_exec_i && swi_num_i <= cpurf_pkg::SWI_STACK_MAX) begin
        flags.stack_sel <= 1'b0;
      end
    end
  end

  // Acceptance: level must beat the current level; enable gates maskables
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_accept_o <= 1'b0;
    end else begin
      irq_accept_o <= irq_req_i & ~irq_ack_i &
                      (~irq_maskable_i | flags.irq_en) &
                      (irq_level_i > flags.processor_priority_level);
    end
  end

  // Wishbone answer: one wait state, ack dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req & ~wb_ack_o;
      if (bus_req && !wb_ack_o) begin
        // Unmapped offsets answer with zero and ignore writes
        wb_dat_o <= wb_adr_i[7] ? 32'h0000_0000 : read_word(bus_idx);
      end
    end
  end

  // Datapath read port, one cycle after the index
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ex_rdata_o <= 32'h0000_0000;
    end else begin
      ex_rdata_o <= read_word(ex_ridx_i);
    end
  end

  // Registered views for the address and stack logic
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pc_o <= PC_W'(cpurf_pkg::ADDR_RST);
      vtab_o <= VTAB_W'(cpurf_pkg::ADDR_RST);
      active_sp_o <= cpurf_pkg::DATA_RST;
      frame_base_o <= cpurf_pkg::DATA_RST;
      static_base_o <= cpurf_pkg::DATA_RST;
      flags_o <= cpurf_pkg::FLAG_RST;
    end else begin
      pc_o <= pc;
      vtab_o <= vtab;
      active_sp_o <= flags.stack_sel ? user_sp : irq_sp;
      frame_base_o <= bank_regs[bank][6];
      static_base_o <= static_base;
      flags_o <= flags;
    end
  end

endmodule

// file: test/cpurf_core_asserts.sv
// Timing checker for the CPU register set, watching top-level ports only.
// Assumes one clock domain and the synchronous active-high reset.
`timescale 1ns/10ps
module cpurf_core_asserts (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire cpurf_pkg::cpurf_alu_type alu_i,
  input wire logic irq_req_i,
  input wire logic irq_maskable_i,
  input wire logic [2:0] irq_level_i,
  input wire logic irq_ack_i,
  input wire logic swi_exec_i,
  input wire logic [5:0] swi_num_i,
  input wire logic irq_accept_o,
  input wire cpurf_pkg::cpurf_flags_type flags_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic z_exp;
  logic s_exp;
  // Byte results judge zero and sign on the low byte only
  assign z_exp = alu_i.byte_op ? (alu_i.result[7:0] == 8'h00) : (alu_i.result == 16'h0000);
  assign s_exp = alu_i.byte_op ? alu_i.result[7] : alu_i.result[15];
  // Request, result and two-edge lag steps; flags_o lags storage by one edge
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_alu;
    alu_i.upd;
  endsequence
  sequence s_lag;
    ##2 1'b1;
  endsequence
  property p_ack_lat;
    s_req |=> wb_ack_o;
  endproperty
  a_ack_lat: assert property (p_ack_lat) else $error("ack late");
  property p_ack_drop;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("ack held");
  property p_unmapped;
    s_req and (!wb_we_i && wb_adr_i[7]) |=> wb_dat_o == 32'h00000000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
  property p_carry;
    s_alu |-> s_lag ##0 flags_o.carry == $past(alu_i.carry, 2);
  endproperty
  a_carry: assert property (p_carry) else $error("carry wrong");
  property p_zero;
    s_alu |-> s_lag ##0 flags_o.zero == $past(z_exp, 2);
  endproperty
  a_zero: assert property (p_zero) else $error("zero wrong");
  property p_sign;
    s_alu |-> s_lag ##0 flags_o.sign == $past(s_exp, 2);
  endproperty
  a_sign: assert property (p_sign) else $error("sign wrong");
  property p_ovf;
    s_alu |-> s_lag ##0 flags_o.ovf == $past(alu_i.ovf, 2);
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow wrong");
  property p_ien_clr;
    irq_ack_i |-> ##2 !flags_o.irq_en;
  endproperty
  a_ien_clr: assert property (p_ien_clr) else $error("enable kept");
  property p_hw_stack;
    irq_ack_i |-> ##2 !flags_o.stack_sel;
  endproperty
  a_hw_stack: assert property (p_hw_stack) else $error("stack kept on ack");
  property p_swi_stack;
    swi_exec_i && swi_num_i <= 6'h1f |-> ##2 !flags_o.stack_sel;
  endproperty
  a_swi_stack: assert property (p_swi_stack) else $error("stack kept on swi");
  property p_accept;
    !$past(rst_i) |-> irq_accept_o == ($past(irq_req_i) && !$past(irq_ack_i) &&
      (!$past(irq_maskable_i) || flags_o.irq_en) && $past(irq_level_i) > flags_o.processor_priority_level);
  endproperty
  a_accept: assert property (p_accept) else $error("accept wrong");
endmodule

bind cpurf_core cpurf_core_asserts cpurf_core_asserts_inst (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .alu_i(alu_i), .irq_req_i(irq_req_i), .irq_maskable_i(irq_maskable_i),
  .irq_level_i(irq_level_i), .irq_ack_i(irq_ack_i), .swi_exec_i(swi_exec_i),
  .swi_num_i(swi_num_i), .irq_accept_o(irq_accept_o), .flags_o(flags_o));

// file: test/cpurf_exec_model.sv
// Behavioural execution datapath and interrupt logic facing the register set.
// Assumes the shared clock; every output changes just after a rising edge.
`timescale 1ns/10ps
module cpurf_exec_model (
  input wire logic clk_i,
  output cpurf_pkg::cpurf_wr_type ex_wr_o,
  output logic [4:0] ex_ridx_o,
  output cpurf_pkg::cpurf_alu_type alu_o,
  output logic irq_req_o,
  output logic irq_maskable_o,
  output logic [2:0] irq_level_o,
  output logic irq_ack_o,
  output logic swi_exec_o,
  output logic [5:0] swi_num_o
);
  // Idle until a task asks for work
  initial begin
    ex_wr_o = '0;
    ex_ridx_o = 5'h00;
    alu_o = '0;
    {irq_req_o, irq_maskable_o, irq_level_o, irq_ack_o} = 6'h00;
    swi_exec_o = 1'b0;
    swi_num_o = 6'h00;
  end
  // One arithmetic result, offered for a single edge
  task automatic alu_op(input logic bo, input logic [15:0] r, input logic c, input logic o);
    @(posedge clk_i);
    alu_o <= '{1'b1, bo, r, c, o};
    @(posedge clk_i);
    alu_o.upd <= 1'b0;
  endtask
  // Request lines stay as set until changed again
  task automatic irq_set(input logic q, input logic m, input logic [2:0] l);
    @(posedge clk_i);
    irq_req_o <= q;
    irq_maskable_o <= m;
    irq_level_o <= l;
  endtask
  // Acknowledge or software interrupt pulse; hw selects the kind
  task automatic irq_pulse(input logic hw, input logic [5:0] n);
    @(posedge clk_i);
    irq_ack_o <= hw;
    swi_exec_o <= !hw;
    swi_num_o <= n;
    @(posedge clk_i);
    irq_ack_o <= 1'b0;
    swi_exec_o <= 1'b0;
  endtask
  // Datapath register write and read index
  task automatic ex_access(input logic [4:0] i, input logic [31:0] d);
    @(posedge clk_i);
    ex_wr_o <= '{1'b1, i, 4'hf, d};
    ex_ridx_o <= i;
    @(posedge clk_i);
    ex_wr_o.we <= 1'b0;
  endtask
endmodule

// file: test/cpurf_core_test.sv
// Self-checking bench for the CPU register set through its Wishbone port.
// Assumes the datapath model drives every execution and interrupt input.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin \
  n_checks++; \
  if ((g) !== (e)) begin \
    n_mismatch++; \
    $display("[ERR] %s exp %h got %h", nm, e, g); \
  end \
end
module cpurf_core_test;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] wb_wdat = 32'h00000000;
  logic [31:0] wb_rdat;
  logic wb_ack;
  cpurf_pkg::cpurf_wr_type ex_wr;
  cpurf_pkg::cpurf_alu_type alu;
  cpurf_pkg::cpurf_flags_type flags;
  logic [4:0] ex_ridx;
  logic [31:0] ex_rdata;
  logic irq_req;
  logic irq_msk;
  logic [2:0] irq_lvl;
  logic irq_ack;
  logic swi_exec;
  logic [5:0] swi_num;
  logic irq_accept;
  logic [19:0] pc;
  logic [15:0] act_sp;
  logic [19:0] vtab;
  logic [15:0] fbase;
  logic [15:0] sbase;
  int n_checks = 0;
  int n_mismatch = 0;
  logic [15:0] v [4];

  // Free-running 40 MHz clock
  always #12.5 clk_i = ~clk_i;

  cpurf_core cpurf_core_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
    .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .ex_wr_i(ex_wr),
    .ex_ridx_i(ex_ridx), .ex_rdata_o(ex_rdata), .alu_i(alu), .irq_req_i(irq_req),
    .irq_maskable_i(irq_msk), .irq_level_i(irq_lvl), .irq_ack_i(irq_ack),
    .swi_exec_i(swi_exec), .swi_num_i(swi_num), .irq_accept_o(irq_accept), .pc_o(pc),
    .vtab_o(vtab), .active_sp_o(act_sp), .frame_base_o(fbase), .static_base_o(sbase),
    .flags_o(flags));
  cpurf_exec_model cpurf_exec_model_inst (.clk_i(clk_i), .ex_wr_o(ex_wr),
    .ex_ridx_o(ex_ridx), .alu_o(alu), .irq_req_o(irq_req), .irq_maskable_o(irq_msk),
    .irq_level_o(irq_lvl), .irq_ack_o(irq_ack), .swi_exec_o(swi_exec), .swi_num_o(swi_num));

  // Verdict and end of run
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Classic single cycle; held until ack is sampled high, bounded wait
  task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [3:0] s,
                         input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_wdat} <= {2'b11, w, a, s, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack !== 1'b1 && n < 20);
    q = wb_rdat;
    {wb_cyc, wb_stb} <= 2'b00;
    if (n >= 20) begin
      n_mismatch++;
      $display("[ERR] wb_ack_o exp 1 got 0");
      final_report();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
    logic [31:0] q;
    wb_xfer(1'b1, a, s, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    logic [31:0] q;
    wb_xfer(1'b0, a, 4'hf, 32'h00000000, q);
    `CHK($sformatf("adr %h", a), e, q & m)
  endtask
  // Interrupt request held three edges, then withdrawn
  task automatic irq_chk(input logic m, input logic [2:0] l, input logic e);
    cpurf_exec_model_inst.irq_set(1'b1, m, l);
    repeat (2) @(posedge clk_i);
    `CHK("irq_accept_o", e, irq_accept)
    cpurf_exec_model_inst.irq_set(1'b0, 1'b0, 3'h0);
  endtask

  // Main sequence; flag writes always keep the debug bit clear
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 13; i++) begin
      rd(8'(i * 4), 32'h00000000, 32'hfffff7ff);
    end
    for (int i = 0; i < 4; i++) begin
      v[i] = 16'h1234 + 16'(i) * 16'h1111;
      wr(8'(i * 4), 4'hf, {16'hdead, v[i]});
      rd(8'(i * 4), {16'h0000, v[i]}, 32'hffffffff);
    end
    rd(8'h38, {v[2], v[0]}, 32'hffffffff);
    rd(8'h3c, {v[3], v[1]}, 32'hffffffff);
    wr(8'h00, 4'h1, 32'h000000ab);
    wr(8'h04, 4'h2, 32'h0000cd00);
    rd(8'h00, {16'h0000, v[0][15:8], 8'hab}, 32'hffffffff);
    rd(8'h04, {16'h0000, 8'hcd, v[1][7:0]}, 32'hffffffff);
    wr(8'h10, 4'h3, 32'h00005a5a);
    wr(8'h14, 4'h3, 32'h0000a5a5);
    rd(8'h40, 32'ha5a55a5a, 32'hffffffff);
    wr(8'h18, 4'h3, 32'h0000beef);
    wr(8'h2c, 4'h3, 32'h0000feed);
    rd(8'h2c, 32'h0000feed, 32'hffffffff);
    `CHK("static_base_o", 16'hfeed, sbase)
    wr(8'h1c, 4'hf, 32'hfff12345);
    wr(8'h1c, 4'h3, 32'h00000000);
    rd(8'h1c, 32'h00012345, 32'hffffffff);
    `CHK("vtab_o", 20'h12345, vtab)
    wr(8'h20, 4'hf, 32'h000abcde);
    rd(8'h20, 32'h000abcde, 32'hffffffff);
    `CHK("pc_o", 20'habcde, pc)
    // Bank 1 starts clear and leaves bank 0 untouched
    wr(8'h30, 4'h3, 32'h00000010);
    rd(8'h00, 32'h00000000, 32'hffffffff);
    wr(8'h00, 4'h3, 32'h00007777);
    wr(8'h30, 4'h3, 32'h00000000);
    rd(8'h00, {16'h0000, v[0][15:8], 8'hab}, 32'hffffffff);
    rd(8'h18, 32'h0000beef, 32'hffffffff);
    `CHK("frame_base_o", 16'hbeef, fbase)
    wr(8'h24, 4'h3, 32'h00001000);
    wr(8'h28, 4'h3, 32'h00002000);
    rd(8'h34, 32'h00002000, 32'hffffffff);
    wr(8'h30, 4'h3, 32'h00000080);
    rd(8'h34, 32'h00001000, 32'hffffffff);
    `CHK("active_sp_o", 16'h1000, act_sp)
    // Arithmetic results reach the condition flags
    cpurf_exec_model_inst.alu_op(1'b0, 16'h8000, 1'b1, 1'b1);
    rd(8'h30, 32'h000000a9, 32'h000007ff);
    cpurf_exec_model_inst.alu_op(1'b1, 16'h1200, 1'b0, 1'b0);
    rd(8'h30, 32'h00000084, 32'h000007ff);
    `CHK("flags_o", 11'h084, flags)
    // Level must exceed the current one; enable masks only maskable ones
    wr(8'h30, 4'h3, 32'h000003c0);
    irq_chk(1'b1, 3'h4, 1'b1);
    irq_chk(1'b1, 3'h3, 1'b0);
    wr(8'h30, 4'h3, 32'h00000380);
    irq_chk(1'b1, 3'h7, 1'b0);
    irq_chk(1'b0, 3'h7, 1'b1);
    // Request withdrawn by now; status shows no acceptance and level 3
    rd(8'h44, 32'h00000006, 32'hffffffff);
    wr(8'h30, 4'h3, 32'h000003c0);
    cpurf_exec_model_inst.irq_pulse(1'b1, 6'h00);
    rd(8'h30, 32'h00000300, 32'h000007ff);
    wr(8'h30, 4'h3, 32'h00000080);
    cpurf_exec_model_inst.irq_pulse(1'b0, 6'h20);
    rd(8'h30, 32'h00000080, 32'h000007ff);
    cpurf_exec_model_inst.irq_pulse(1'b0, 6'h1f);
    rd(8'h30, 32'h00000000, 32'h000007ff);
    wr(8'h30, 4'h3, 32'h000007fd);
    rd(8'h30, 32'h000007fd, 32'h000007ff);
    rd(8'h80, 32'h00000000, 32'hffffffff);
    cpurf_exec_model_inst.ex_access(cpurf_pkg::IDX_DATA3, 32'h00004321);
    // Write lands at the strobe edge; the read port shows it one edge later
    repeat (2) @(posedge clk_i);
    `CHK("ex_rdata_o", 32'h00004321, ex_rdata)
    rd(8'h0c, 32'h00004321, 32'hffffffff);
    final_report();
  end
endmodule
